// file: common/dmtr_regs.vh
// Mode register addresses, field positions and codes for the drive/temperature/id bank
`ifndef DMTR_REGS_VH
`define DMTR_REGS_VH

`define DMTR_ADDR_DRIVE 8'h03
`define DMTR_ADDR_TEMP 8'h04
`define DMTR_ADDR_MAKER 8'h05
`define DMTR_ADDR_REV1 8'h06
`define DMTR_ADDR_REV2 8'h07

`define DMTR_DRIVE_MSB 3
`define DMTR_DRIVE_LSB 0
`define DMTR_DRIVE_RESET 4'h2
`define DMTR_DRV_40 4'h2
`define DMTR_DRV_48 4'h3
`define DMTR_DRV_60 4'h4
`define DMTR_DRV_80 4'h6
`define DMTR_DRV_ASYM_A 4'h9
`define DMTR_DRV_ASYM_B 4'ha

`define DMTR_TUF_BIT 7
`define DMTR_RATE_MSB 2
`define DMTR_RATE_LSB 0
`define DMTR_HOT_BIT 2
`define DMTR_RATE_RESET 3'h3

`define DMTR_RATE_LOW_LIMIT 3'h0
`define DMTR_RATE_X4 3'h1
`define DMTR_RATE_X2 3'h2
`define DMTR_RATE_X1 3'h3
`define DMTR_RATE_HALF 3'h4
`define DMTR_RATE_QUARTER 3'h5
`define DMTR_RATE_QUARTER_DERATE 3'h6
`define DMTR_RATE_HIGH_LIMIT 3'h7

`endif

// file: src/dmtr_mode_regs.v
// Drive strength, temperature status and identification mode registers
// Functional notes
// - Write-only 4-bit drive select at address 03h; listed codes, others reserved.
// - Rate code 000 means low limit exceeded, 111 high limit exceeded.
// - Rate codes 001..101 give multipliers 4x, 2x, 1x, 0.5x, 0.25x.
// - Rate code 110 is 0.25x and asks the controller to derate timing.
// - Reading address 04h clears the update flag after returning current value.
// - Update flag sets when rate field changes since the last status read.
// - Update flag is zero after reset; rate field resets to code 011 (1x).
// - Rate bit 2 high means device is above 85 degrees Celsius.
// - Address 05h returns fixed maker code; writes ignored.
// - Address 06h returns first revision code; read-only.
// - Address 07h returns second revision code; read-only.
`timescale 1ns/1ps
`include "dmtr_regs.vh"

module dmtr_mode_regs #(
  parameter [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter [7:0] REV_ID1 = 8'h01, // Arbitrary value
  parameter [7:0] REV_ID2 = 8'h00 // Arbitrary value
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_mrw,
  input wire i_mrr,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [2:0] i_sensor_rate,
  output reg o_rvalid,
  output reg [7:0] o_rdata,
  output reg [3:0] o_output_drive_select,
  output reg [2:0] o_refresh_multiplier,
  output reg o_temperature_update_flag,
  output reg o_over_85c,
  output reg o_derate_req,
  output reg o_out_of_range
);

  reg [2:0] nxt_rate;
  reg nxt_tuf;
  reg [7:0] nxt_rdata;

  function rate_derates;
    input [2:0] code;
    begin
      rate_derates = (code == `DMTR_RATE_QUARTER_DERATE);
    end
  endfunction

  function rate_outside;
    input [2:0] code;
    begin
      rate_outside = (code == `DMTR_RATE_LOW_LIMIT) || (code == `DMTR_RATE_HIGH_LIMIT);
    end
  endfunction

  // Read data mux; status read returns the flag before it is cleared
  always @* begin
    nxt_rdata = 8'h00;
    case (i_addr)
      `DMTR_ADDR_TEMP: begin
        nxt_rdata[`DMTR_TUF_BIT] = o_temperature_update_flag;
        nxt_rdata[`DMTR_RATE_MSB:`DMTR_RATE_LSB] = o_refresh_multiplier;
      end
      `DMTR_ADDR_MAKER: nxt_rdata = MAKER_ID;
      `DMTR_ADDR_REV1: nxt_rdata = REV_ID1;
      `DMTR_ADDR_REV2: nxt_rdata = REV_ID2;
      default: nxt_rdata = 8'h00; // Drive register is write-only
    endcase
  end

  // Change sets the flag and wins over a same-cycle read clear
  always @* begin
    nxt_rate = i_sensor_rate;
    nxt_tuf = o_temperature_update_flag;
    if (i_mrr && (i_addr == `DMTR_ADDR_TEMP)) begin
      nxt_tuf = 1'b0;
    end
    if (nxt_rate != o_refresh_multiplier) begin
      nxt_tuf = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 8'h00;
      o_output_drive_select <= `DMTR_DRIVE_RESET;
      o_refresh_multiplier <= `DMTR_RATE_RESET;
      o_temperature_update_flag <= 1'b0;
      o_over_85c <= 1'b0;
      o_derate_req <= 1'b0;
      o_out_of_range <= 1'b0;
    end else begin
      o_rvalid <= i_mrr;
      if (i_mrr) begin
        o_rdata <= nxt_rdata;
      end
      // Only the drive register accepts writes
      if (i_mrw && (i_addr == `DMTR_ADDR_DRIVE)) begin
        o_output_drive_select <= i_wdata[`DMTR_DRIVE_MSB:`DMTR_DRIVE_LSB];
      end
      o_refresh_multiplier <= nxt_rate;
      o_temperature_update_flag <= nxt_tuf;
      o_over_85c <= nxt_rate[`DMTR_HOT_BIT];
      o_derate_req <= rate_derates(nxt_rate);
      o_out_of_range <= rate_outside(nxt_rate);
    end
  end

endmodule // dmtr_mode_regs

// file: verif/dmtr_props.sv
// Port checker for the mode registers
`timescale 1ns/1ps
module dmtr_props(input wire i_clk,i_srst,i_mrw,i_mrr,o_rvalid,o_temperature_update_flag,
  o_over_85c,o_derate_req,o_out_of_range,input wire [7:0] i_addr,i_wdata,o_rdata,
  input wire [3:0] o_output_drive_select,input wire [2:0] i_sensor_rate,o_refresh_multiplier);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire w3=i_mrw&&i_addr==8'h03,r4=i_mrr&&i_addr==8'h04,f=o_temperature_update_flag;
  wire [3:0] d=i_wdata[3:0],ds=o_output_drive_select;
  wire [2:0] m=o_refresh_multiplier,s=i_sensor_rate;
  ds_write_a: assert property(w3|=>ds==$past(d)) else $error("bad");
  ds_hold_a: assert property(!w3|=>$stable(ds)) else $error("bad");
  st_read_a: assert property(r4|=>o_rvalid&&o_rdata=={$past(f),4'h0,$past(m)})
    else $error("bad");
  uf_clear_a: assert property(r4&&s==m|=>!f) else $error("bad");
  uf_set_a: assert property(s!=m|=>f) else $error("bad");
  hot_bit_a: assert property(o_over_85c==m[2]) else $error("bad");
  derate_req_a: assert property(o_derate_req==(m==3'h6)) else $error("bad");
  out_range_a: assert property(o_out_of_range==(m==3'h0||m==3'h7)) else $error("bad");
  cover property(r4&&f);
  cover property(o_derate_req);
  cover property(w3);
endmodule // dmtr_props
bind dmtr_mode_regs dmtr_props i_dmtr_props(.*);

// file: verif/dmtr_ctl.sv
// Controller model issuing mode register commands
`timescale 1ns/1ps
module dmtr_ctl(input wire i_clk,input wire [7:0] i_rdata,output reg o_mrw=0,o_mrr=0,
  output reg [7:0] o_addr=0,o_wdata=0);
  // Controller view of the last status read
  reg need_derate=0,not_assured=0;
  // Released address and data show the inverse, not the old value
  task op(input w,input [7:0] a,x,output [7:0] q);
    @(negedge i_clk) {o_mrw,o_mrr,o_addr,o_wdata}={w,!w,a,x};
    @(negedge i_clk) {o_mrw,o_mrr,o_addr,o_wdata}={2'b0,~a,~x};
    q=i_rdata;
    if(!w&&a==8'h04) begin
      need_derate=(q[2:0]==3'h6);
      not_assured=(q[2:0]==3'h0||q[2:0]==3'h7);
    end
  endtask
endmodule // dmtr_ctl

// file: verif/dmtr_mode_regs_tb.sv
// Bench for the mode registers
`timescale 1ns/1ps
module dmtr_mode_regs_tb;
  reg i_clk=0,i_srst=1;
  reg [2:0] i_sensor_rate=3'h3;
  reg [7:0] q;
  wire i_mrw,i_mrr,o_rvalid,o_temperature_update_flag,o_over_85c,o_derate_req,o_out_of_range;
  wire [7:0] i_addr,i_wdata,o_rdata;
  wire [3:0] o_output_drive_select;
  wire [2:0] o_refresh_multiplier;
  int n_errors=0,tests_run=0;
  // Rows: write flag, address, data, expected drive or read byte
  reg [24:0] rows[11]='{25'h1030202,25'h1030303,25'h1030404,25'h1030606,25'h1030909,
    25'h103fa0a,25'h105330a,25'h005005a,25'h0060001,25'h0070000,25'h0030000};
  always #2 i_clk=~i_clk;
  dmtr_mode_regs i_dmtr_mode_regs(.*);
  dmtr_ctl i_dmtr_ctl(.i_clk(i_clk),.i_rdata(o_rdata),.o_mrw(i_mrw),.o_mrr(i_mrr),
    .o_addr(i_addr),.o_wdata(i_wdata));
  task chk(input [7:0] g,e);
    tests_run++;
    if(g!==e) begin n_errors++; $display("Error %0t %h %h",$time,g,e); end
  endtask
  task wrap_up;
    if(n_errors==0&&tests_run>0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat(20) @(negedge i_clk);
    chk({o_rvalid,o_temperature_update_flag,o_output_drive_select},8'h02);
    i_srst=0;
    foreach(rows[k]) begin
      i_dmtr_ctl.op(rows[k][24],rows[k][23:16],rows[k][15:8],q);
      chk(rows[k][24]?{4'h0,o_output_drive_select}:q,rows[k][7:0]);
    end
    for(int c=0;c<8;c++) begin
      i_sensor_rate=c[2:0];
      i_dmtr_ctl.op(0,8'h04,0,q);
      chk(q,{5'h10,c[2:0]});
      chk({o_rvalid,o_over_85c,o_derate_req,o_out_of_range,1'b0,o_refresh_multiplier},{1'b1,c[2],c==6,c==0||c==7,1'b0,c[2:0]});
      chk({6'h0,i_dmtr_ctl.need_derate,i_dmtr_ctl.not_assured},{6'h0,c==6,c==0||c==7});
      i_dmtr_ctl.op(0,8'h04,0,q);
      chk(q,{5'h0,c[2:0]});
    end
    wrap_up;
  end
endmodule // dmtr_mode_regs_tb
